// ---- include/peap_pkg.sv ----
/*
 Package for the parallel memory port controller: pin group structs,
 command codes, state codes and timing counts.
 Assumes a 100 MHz reference clock; all pins are sampled synchronously.
*/
package peap_pkg;

   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int ARRAY_BYTES = 2048;
   localparam int TOP_BIT = 7;
   localparam logic [10:0] ID_FIRST = 11'h7e0;
   localparam logic [10:0] ID_LAST = 11'h7ff;
   localparam int ID_BYTES = 32;

   // Timing in ns, cycles derived at 10 ns per cycle
   localparam int CLK_NS = 10;
   localparam int T_AS_NS = 10;
   localparam int T_WP_NS = 100;
   localparam int T_DH_NS = 10;
   localparam int T_ACC_NS = 150;
   localparam int T_DF_NS = 50;
   localparam int T_AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_DH_CYC = (T_DH_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_DF_CYC = (T_DF_NS + CLK_NS - 1) / CLK_NS;
   // Long times in us, defaults of top parameters
   localparam int T_WC_US = 1000;
   localparam int T_PON_US = 5000;
   localparam int T_CLR_US = 10000;
   localparam int CYC_PER_US = 1000 / CLK_NS;
   localparam int T_WC_CYC = T_WC_US * CYC_PER_US;
   localparam int T_PON_CYC = T_PON_US * CYC_PER_US;
   localparam int T_CLR_CYC = T_CLR_US * CYC_PER_US;

   typedef enum logic [1:0] {
      PEAP_CMD_READ  = 2'h0,
      PEAP_CMD_WRITE = 2'h1,
      PEAP_CMD_CLEAR = 2'h2
   } peap_cmd_t;

   typedef struct packed {
      peap_cmd_t           cmd;
      logic                id_area;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } peap_req_t;

   typedef struct packed {
      logic                chip_sel_n;
      logic                out_en_n;
      logic                oe_high_volt;
      logic                wr_n;
      logic                id_area_select_line;
      logic [ADDR_W-1:0]   address_lines;
      logic [DATA_W-1:0]   data_out;
      logic                data_oe;
   } peap_pins_t;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_SETUP = 8'h02,
      ST_PULSE = 8'h04,
      ST_HOLD  = 8'h08,
      ST_POLL  = 8'h10,
      ST_READ  = 8'h20,
      ST_FLOAT = 8'h40,
      ST_DONE  = 8'h80
   } peap_state_t;

endpackage

// ---- rtl/peap_timer.sv ----
/*
 Down counter used for every sequencer wait but the write poll bound, counted on wc_q; the power-on hold-off has its own counter.
 Assumes load and count come from one clocked owner; one clock.
*/
`timescale 1ns/100ps
module peap_timer #(
   parameter int W = 24
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              expired
);

   logic [W-1:0] cnt_q;

   // Load wins over counting so a new wait always restarts cleanly
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= value;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   // Plain compare: gating with load would close a loop through the caller's reload
   assign expired = (cnt_q == '0);

endmodule

// ---- rtl/peap_host.sv ----
/*
 Host controller for a 2,048 x 8 byte-wide self-timed nonvolatile memory.
 Takes read, byte write and chip clear requests and drives the memory pins.
 Assumes all inputs synchronous to ref_clk, data_in is the resolved bus,
 and an external switch turns oe_high_volt / id_area_select_line into 12 V.
*/
`timescale 1ns/100ps
module peap_host
   import peap_pkg::*;
#(
   parameter int WC_CYC = T_WC_CYC,
   parameter int PON_CYC = T_PON_CYC,
   parameter int CLR_CYC = T_CLR_CYC,
   parameter int TW = 24
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              req_valid,
   input  peap_pkg::peap_req_t    req,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [7:0]             rsp_data,
   output logic                   rsp_timeout,
   output peap_pkg::peap_pins_t   pins,
   input  wire logic [7:0]        data_in
);
   import peap_pkg::*;

   peap_state_t       st_q;
   peap_req_t         cur_q;
   logic              pon_q;
   logic              tmr_load;
   logic [TW-1:0]     tmr_val;
   logic              tmr_exp;
   logic [TW-1:0]     wc_q;
   logic              match;

   ////////////////////////////////////////////////////////////////////
   // Shared wait timer
   peap_timer #(.W(TW)) u_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .load    (tmr_load),
      .value   (tmr_val),
      .expired (tmr_exp)
   );

   // Top bit equals the written value once programming ends
   assign match = (data_in[TOP_BIT] == cur_q.wdata[TOP_BIT]);

   // Timer reload on every state entry except ST_DONE and ST_IDLE
   always_comb begin
      tmr_load = 1'b0;
      tmr_val = '0;
      unique case (st_q)
         ST_IDLE: begin
            if (req_valid && req_ready) begin
               tmr_load = 1'b1;
               tmr_val = TW'(T_AS_CYC);
            end
         end
         ST_SETUP: begin
            if (tmr_exp) begin
               tmr_load = 1'b1;
               tmr_val = (cur_q.cmd == PEAP_CMD_READ) ? TW'(T_ACC_CYC) :
                         (cur_q.cmd == PEAP_CMD_CLEAR) ? TW'(CLR_CYC) :
                         TW'(T_WP_CYC);
            end
         end
         ST_PULSE: begin
            if (tmr_exp) begin
               tmr_load = 1'b1;
               tmr_val = TW'(T_DH_CYC);
            end
         end
         ST_HOLD, ST_POLL: begin
            if (tmr_exp && st_q == ST_HOLD) begin
               tmr_load = 1'b1;
               tmr_val = TW'(T_ACC_CYC);
            end
            // Poll exit also waits out the memory's bus float time
            if (st_q == ST_POLL && ((tmr_exp && match) || wc_q >= TW'(WC_CYC))) begin
               tmr_load = 1'b1;
               tmr_val = TW'(T_DF_CYC);
            end
         end
         ST_READ: begin
            if (tmr_exp) begin
               tmr_load = 1'b1;
               tmr_val = TW'(T_DF_CYC);
            end
         end
         ST_FLOAT, ST_DONE: begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Power-on hold-off before any request
   logic pon_busy_q;
   logic [TW-1:0] pon_cnt_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pon_cnt_q <= '0;
         pon_q <= 1'b0;
      end else if (!pon_q) begin
         pon_cnt_q <= pon_cnt_q + TW'(1);
         pon_q <= (pon_cnt_q >= TW'(PON_CYC - 1));
      end
   end
   assign pon_busy_q = !pon_q;

   ////////////////////////////////////////////////////////////////////
   // Sequencer; one access at a time keeps polling honest
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         cur_q <= '0;
         wc_q <= '0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (req_valid && req_ready) begin
                  cur_q <= req;
                  st_q <= ST_SETUP;
               end
            end
            ST_SETUP: if (tmr_exp) st_q <= (cur_q.cmd == PEAP_CMD_READ) ? ST_READ : ST_PULSE;
            ST_PULSE: if (tmr_exp) st_q <= ST_HOLD;
            ST_HOLD: begin
               if (tmr_exp) begin
                  wc_q <= '0;
                  st_q <= (cur_q.cmd == PEAP_CMD_WRITE) ? ST_POLL : ST_FLOAT;
               end
            end
            ST_POLL: begin
               wc_q <= wc_q + TW'(1);
               if ((tmr_exp && match) || wc_q >= TW'(WC_CYC)) begin
                  st_q <= ST_FLOAT;
               end
            end
            ST_READ: if (tmr_exp) st_q <= ST_FLOAT;
            ST_FLOAT: if (tmr_exp) st_q <= ST_DONE;
            ST_DONE: st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin drive, all registered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, oe_high_volt: 1'b0, wr_n: 1'b1,
                   id_area_select_line: 1'b0, address_lines: '0, data_out: '0,
                   data_oe: 1'b0};
      end else begin
         pins.address_lines <= cur_q.addr;
         pins.id_area_select_line <= cur_q.id_area && (cur_q.addr >= ID_FIRST);
         unique case (st_q)
            ST_SETUP: begin
               pins.chip_sel_n <= 1'b0;
               // Read enables output; write and clear keep it high
               pins.out_en_n <= (cur_q.cmd != PEAP_CMD_READ);
               pins.oe_high_volt <= (cur_q.cmd == PEAP_CMD_CLEAR);
               pins.wr_n <= !(tmr_exp && cur_q.cmd != PEAP_CMD_READ);
               pins.data_out <= cur_q.wdata;
               pins.data_oe <= (cur_q.cmd == PEAP_CMD_WRITE);
            end
            ST_PULSE: begin
               if (tmr_exp) pins.wr_n <= 1'b1;
            end
            ST_HOLD: begin
               // Data held past strobe rise, then bus released
               if (tmr_exp) begin
                  pins.data_oe <= 1'b0;
                  pins.oe_high_volt <= 1'b0;
                  pins.out_en_n <= (cur_q.cmd != PEAP_CMD_WRITE);
               end
            end
            ST_READ, ST_POLL: begin
               pins.out_en_n <= 1'b0;
            end
            ST_FLOAT: begin
               pins.out_en_n <= 1'b1;
               pins.chip_sel_n <= 1'b1;
            end
            default: begin
               pins.out_en_n <= 1'b1;
               pins.chip_sel_n <= 1'b1;
               pins.wr_n <= 1'b1;
               pins.data_oe <= 1'b0;
               pins.oe_high_volt <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Response and handshake
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_timeout <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         req_ready <= (st_q == ST_IDLE) && !pon_busy_q && !(req_valid && req_ready);
         if (st_q == ST_READ && tmr_exp) rsp_data <= data_in;
         if (st_q == ST_POLL && (tmr_exp && match)) rsp_data <= data_in;
         if (st_q == ST_HOLD && tmr_exp) rsp_timeout <= 1'b0;
         if (st_q == ST_POLL && !(tmr_exp && match) && wc_q >= TW'(WC_CYC))
            rsp_timeout <= 1'b1;
         if (st_q == ST_DONE) rsp_valid <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_write_oe_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pins.wr_n |-> pins.out_en_n) else $error("strobe low with output enable low");
   a_write_cs_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pins.wr_n |-> !pins.chip_sel_n) else $error("strobe low without select");
   a_no_contention: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pins.data_oe |-> pins.out_en_n) else $error("host drives during memory read");
   a_data_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(pins.wr_n) && pins.data_oe |=> pins.data_oe) else $error("data hold lost");
   a_addr_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pins.wr_n |=> $stable(pins.address_lines)) else $error("address moved");
   a_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(pins.wr_n) && pins.data_oe |-> (!pins.wr_n)[*8]) else $error("pulse short");
   a_pon_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pon_q |-> !req_ready) else $error("ready before power-on delay");
   a_clear_hv: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pins.oe_high_volt |-> !pins.chip_sel_n) else $error("high voltage without select");
   a_poll_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == ST_POLL |-> wc_q <= TW'(WC_CYC)) else $error("poll exceeded bound");
   // A write that did not time out answers only after its top bit was seen to match
   a_poll_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rsp_valid && !rsp_timeout && cur_q.cmd == PEAP_CMD_WRITE
      |-> rsp_data[TOP_BIT] == cur_q.wdata[TOP_BIT]) else $error("write answer not polled");

endmodule

// ---- sim/peap_mem_model.sv ----
/*
 Behavioural model of the byte-wide self-timed memory on the far side of the
 host controller. Assumes the resolved data bus is worked out here from the
 host's output enable and the model's own drive; one clock samples all pins.
*/
`timescale 1ns/100ps
module peap_mem_model
   import peap_pkg::*;
#(
   parameter int BUSY_CYC = 40,
   parameter int SLOW_CYC = 300,
   parameter int PON_CYC  = 10,
   parameter int CLR_CYC  = 48,
   parameter int OE_CYC   = 10
) (
   input  wire logic            ref_clk,
   input  peap_pkg::peap_pins_t pins,
   input  wire logic            slow,
   output logic [7:0]           data_in
);
   logic [7:0]  mem_q [0:ARRAY_BYTES+ID_BYTES-1];
   logic [11:0] idx;
   logic [11:0] wa_q;
   logic [7:0]  wd_q;
   logic [7:0]  last_q;
   logic [7:0]  rdata;
   logic        wr_prev_q;
   logic        arm_q;
   logic        drv;
   logic        start;
   int          busy_q;
   int          pon_q;
   int          low_q;
   int          acc_q;

   ////////////////////////////////////////////////////////////////////////////
   // Decode; the id area overlays the top 32 addresses
   assign idx = pins.id_area_select_line ? 12'(ARRAY_BYTES) + 12'(pins.address_lines[4:0])
                                         : {1'b0, pins.address_lines};
   assign start = wr_prev_q && !pins.wr_n && !pins.chip_sel_n && pins.out_en_n
                  && !pins.oe_high_volt && busy_q == 0 && !arm_q
                  && pon_q >= PON_CYC;
   assign drv = !pins.chip_sel_n && !pins.out_en_n && pins.wr_n
                && !pins.oe_high_volt;
   assign rdata = (busy_q != 0 && idx == wa_q) ? {~wd_q[7], ~last_q[6:0]}
                                                : mem_q[idx];
   // No pull on the bus: a released bus shows the inverse of its last level
   assign data_in = pins.data_oe ? pins.data_out :
                    (drv && acc_q >= OE_CYC) ? rdata : ~last_q;

   initial begin
      for (int i = 0; i < ARRAY_BYTES + ID_BYTES; i++) mem_q[i] = 8'h00;
      wr_prev_q = 1'b1;
      arm_q = 1'b0;
      wa_q = 12'h000;
      wd_q = 8'h00;
      last_q = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write latch, self-timed busy period and chip clear
   always @(posedge ref_clk) begin
      wr_prev_q <= pins.wr_n;
      last_q <= data_in;
      acc_q <= drv ? acc_q + 1 : 0;
      if (pon_q < PON_CYC) pon_q <= pon_q + 1;
      if (start) begin
         arm_q <= 1'b1;
         wa_q <= idx;
      end
      if (arm_q && (pins.wr_n || pins.chip_sel_n)) begin
         arm_q <= 1'b0;
         wd_q <= pins.data_out;
         busy_q <= slow ? SLOW_CYC : BUSY_CYC;
      end
      if (busy_q > 1) busy_q <= busy_q - 1;
      if (busy_q == 1) begin
         busy_q <= 0;
         mem_q[wa_q] <= wd_q;
      end
      low_q <= (!pins.chip_sel_n && pins.oe_high_volt && !pins.wr_n) ? low_q + 1 : 0;
      if (pins.wr_n && low_q >= CLR_CYC) begin
         for (int i = 0; i < ARRAY_BYTES; i++) mem_q[i] <= 8'hff;
      end
   end
endmodule

// ---- sim/testbench.sv ----
/*
 Self-checking bench for the host controller with the memory model.
 Assumes shortened power-on, write and clear counts set as parameters here.
*/
`timescale 1ns/100ps
module testbench;
   import peap_pkg::*;
   localparam int WC = 200;
   localparam int PON = 20;
   localparam int CLR = 50;
   logic        ref_clk;
   logic        rst_n;
   logic        req_valid;
   peap_req_t   req;
   logic        req_ready;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic        rsp_timeout;
   peap_pins_t  pins;
   logic [7:0]  data_in;
   logic        slow;
   int          n_errors;
   int          samples_checked;
   int          cnt;
   peap_req_t   rows [0:6];
   logic [7:0]  exps [0:6];

   peap_host #(.WC_CYC(WC), .PON_CYC(PON), .CLR_CYC(CLR)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_timeout(rsp_timeout), .pins(pins), .data_in(data_in));
   peap_mem_model #(.CLR_CYC(CLR - 2)) mem_u (
      .ref_clk(ref_clk), .pins(pins), .slow(slow), .data_in(data_in));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // One request, held until taken, then a bounded wait for the answer
   task automatic do_req(input peap_req_t r);
      int n;
      req <= r;
      req_valid <= 1'b1;
      while (req_ready !== 1'b1) @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
      req_valid <= 1'b0;
      for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(posedge ref_clk) #1;
      chk({7'h0, rsp_valid}, 8'h01);
   endtask

   initial begin
      #100000;
      n_errors++;
      stop_test;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      n_errors = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      slow = 1'b0;
      rows[0] = '{PEAP_CMD_WRITE, 1'b0, 11'h000, 8'ha5}; exps[0] = 8'ha5;
      rows[1] = '{PEAP_CMD_READ,  1'b0, 11'h000, 8'h00}; exps[1] = 8'ha5;
      rows[2] = '{PEAP_CMD_WRITE, 1'b0, 11'h7ff, 8'h3c}; exps[2] = 8'h3c;
      rows[3] = '{PEAP_CMD_WRITE, 1'b1, 11'h7e0, 8'h81}; exps[3] = 8'h81;
      rows[4] = '{PEAP_CMD_READ,  1'b1, 11'h7e0, 8'h00}; exps[4] = 8'h81;
      rows[5] = '{PEAP_CMD_READ,  1'b0, 11'h7e0, 8'h00}; exps[5] = 8'h00;
      rows[6] = '{PEAP_CMD_READ,  1'b0, 11'h7ff, 8'h00}; exps[6] = 8'h3c;
      repeat (5) @(posedge ref_clk);
      #1;
      chk({5'h0, pins.chip_sel_n, pins.wr_n, pins.data_oe}, 8'h06);
      chk({7'h0, req_ready}, 8'h00);
      rst_n = 1'b1;
      for (cnt = 0; cnt < PON + 10 && req_ready !== 1'b1; cnt++) @(posedge ref_clk) #1;
      chk({7'h0, cnt >= PON && cnt <= PON + 3}, 8'h01);
      // Ordinary traffic, back to back
      for (int i = 0; i < 7; i++) begin
         do_req(rows[i]);
         chk(rsp_data, exps[i]);
      end
      // Whole array clear, then the cleared places read back as ones
      do_req('{PEAP_CMD_CLEAR, 1'b0, 11'h000, 8'h00});
      do_req('{PEAP_CMD_READ, 1'b0, 11'h000, 8'h00});
      chk(rsp_data, 8'hff);
      do_req('{PEAP_CMD_READ, 1'b1, 11'h7e0, 8'h00});
      chk(rsp_data, 8'h81);
      // Slow memory: polling gives up, next write clears the flag
      slow = 1'b1;
      do_req('{PEAP_CMD_WRITE, 1'b0, 11'h010, 8'h5a});
      chk({7'h0, rsp_timeout}, 8'h01);
      slow = 1'b0;
      repeat (200) @(posedge ref_clk);
      #1;
      chk({7'h0, pins.data_oe | ~pins.chip_sel_n}, 8'h00);
      do_req('{PEAP_CMD_WRITE, 1'b0, 11'h011, 8'h66});
      chk({7'h0, rsp_timeout}, 8'h00);
      do_req('{PEAP_CMD_READ, 1'b0, 11'h010, 8'h00});
      chk(rsp_data, 8'h5a);
      do_req('{PEAP_CMD_READ, 1'b0, 11'h011, 8'h00});
      chk(rsp_data, 8'h66);
      stop_test;
   end
endmodule
